/* File: swc_pkg.sv */
package swc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SWC_ADDR_STATUS = 4'h0;
  localparam logic [3:0] SWC_ADDR_WDCON = 4'h1;
  localparam logic [3:0] SWC_ADDR_IRQ_EN = 4'h2;
  localparam logic [3:0] SWC_ADDR_IRQ_FLAG = 4'h3;

  localparam int SWC_STATUS_TO_BIT = 4;
  localparam int SWC_STATUS_PD_BIT = 3;
  localparam int SWC_WDCON_PS_LSB = 1;
  localparam int SWC_WDCON_EN_BIT = 0;
  localparam int SWC_GIE_BIT = 7;

  localparam logic [4:0] SWC_PS_RESET = 5'h0b;
  localparam logic [4:0] SWC_PS_MAX = 5'h12;
  localparam logic [4:0] SWC_PS_BASE_SHIFT = 5'h05;
  localparam logic [7:0] SWC_IRQ_EN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SWC_CLK_HZ = 10000000;
  localparam int SWC_LFOSC_HZ = 31000;
  // system clocks per low-frequency oscillator tick, rounded down
  localparam int SWC_LF_DIV = SWC_CLK_HZ / SWC_LFOSC_HZ;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0] SWC_MODE_OFF = 2'h0;
  localparam logic [1:0] SWC_MODE_SOFT = 2'h1;
  localparam logic [1:0] SWC_MODE_AWAKE = 2'h2;
  localparam logic [1:0] SWC_MODE_ON = 2'h3;

  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_SLEEP,
    SWC_WAKE
  } swc_state_t;

  typedef struct packed {
    logic sleep;
    logic watchdog_clear_instr;
    logic osc_fail;
    logic osc_div_change;
  } swc_core_req_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swc_bus_req_t;

endpackage

/* File: swc_prescale.sv */
module swc_prescale
  import swc_pkg::*;
#(
  parameter int DIV = SWC_LF_DIV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic clr,
  output logic tick
);

  localparam int W = $clog2(DIV + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } swc_ps_state_t;

  swc_ps_state_t s_q;
  swc_ps_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clr) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == W'(DIV - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

/* File: swc_sleep_wdt.sv */
// Contract
// - sleep entry clears watchdog, clears power-down, sets time-out, stops core clock.
// - low-frequency timebase and pin states keep going through sleep.
// - sleep never masks resets other than the watchdog.
// - hard resets restart; watchdog, external, peripheral interrupts resume execution.
// - wake needs a source enable; global enable plays no part.
// - instruction after sleep is prefetched and runs first after wake.
// - global enable clear: continue in line after wake, no vector.
// - global enable set: run next instruction, then vector to service routine.
// - every wake from sleep clears the watchdog.
// - pending enabled interrupt with global enable clear makes sleep a no-op.
// - interrupt during sleep instruction completes it and wakes at once.
// - high-frequency oscillator may stay on in sleep for waveform users.
// - watchdog resets device when not cleared in time while awake.
// - watchdog counts low-frequency oscillator cycles, base interval shortest.
// - mode 11 always on, 10 awake only, 00 off.
// - mode 01 follows software enable bit, awake and asleep.
// - period field selects time-out, defaulting to two seconds after reset.
// - clear on reset, clear instruction, sleep entry, exit, osc fail, disable.
// - oscillator divider changes leave the watchdog count alone.
// - enabled in sleep: count again from zero, cleared again on exit.
// - time-out in sleep wakes device and updates status flags, no reset.
// - prescale 2^(5+code) up to 10010, reset 01011, reserved codes minimum.
//
// The address map and strobed register access were chosen for this implementation.
module swc_sleep_wdt
  import swc_pkg::*;
#(
  parameter int LF_DIV = SWC_LF_DIV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration word
  input wire logic [1:0] watchdog_mode_cfg,
  // core requests
  input wire swc_core_req_t core_req,
  // interrupt sources
  input wire logic [7:0] irq_flags,
  // register port
  input wire swc_bus_req_t bus,
  output logic [7:0] rdata,
  // core and system control
  output logic cpu_clk_en,
  output logic wake_pulse,
  output logic vector_req,
  output logic wdt_reset_req,
  output logic lf_osc_run,
  output logic hf_osc_keep,
  // oscillator request from waveform users
  input wire logic hf_osc_users
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    swc_state_t st;
    logic [22:0] count;
    logic power_down_flag;
    logic time_out_flag;
    logic [4:0] watchdog_period_sel;
    logic soft_watchdog_enable;
    logic [7:0] irq_en;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic wake_pulse;
    logic vector_req;
    logic wdt_reset_req;
    logic hf_keep;
  } swc_top_state_t;

  swc_top_state_t s_q;
  swc_top_state_t s_d;

  logic lf_tick;
  logic wdt_active;
  logic wdt_clear;
  logic irq_pending;
  logic global_irq_enable;
  logic [22:0] limit;
  logic timeout;

  // ----------------------------------------------------------------
  // low-frequency timebase
  // ----------------------------------------------------------------
  swc_prescale #(
    .DIV(LF_DIV)
  ) u_lf (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(1'b0),
    .tick(lf_tick)
  );

  // ----------------------------------------------------------------
  // watchdog decode
  // ----------------------------------------------------------------
  always_comb begin
    global_irq_enable = s_q.irq_en[SWC_GIE_BIT];
    // wake sources: enable and flag, global bit ignored
    irq_pending = |(s_q.irq_en[6:0] & irq_flags[6:0]);
    case (watchdog_mode_cfg)
      SWC_MODE_ON: wdt_active = 1'b1;
      SWC_MODE_AWAKE: wdt_active = (s_q.st != SWC_SLEEP);
      SWC_MODE_SOFT: wdt_active = s_q.soft_watchdog_enable;
      default: wdt_active = 1'b0;
    endcase
    // reserved codes fall back to the minimum interval
    if (s_q.watchdog_period_sel > SWC_PS_MAX) begin
      limit = 23'(1) << SWC_PS_BASE_SHIFT;
    end else begin
      limit = 23'(1) << (s_q.watchdog_period_sel + SWC_PS_BASE_SHIFT);
    end
    timeout = wdt_active && lf_tick && (s_q.count >= limit - 23'(1));
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wake_pulse = 1'b0;
    s_d.vector_req = 1'b0;
    s_d.wdt_reset_req = 1'b0;
    s_d.hf_keep = hf_osc_users;
    wdt_clear = core_req.watchdog_clear_instr || core_req.osc_fail || !wdt_active;
    // osc_div_change has no effect on the count
    if (core_req.osc_div_change) begin
      wdt_clear = wdt_clear;
    end

    case (s_q.st)
      SWC_RUN: begin
        if (core_req.sleep && !(irq_pending && !global_irq_enable)) begin
          // sleep entry; a flag arriving now wakes at once
          s_d.st = irq_pending ? SWC_WAKE : SWC_SLEEP;
          s_d.cpu_clk_en = irq_pending;
          s_d.power_down_flag = 1'b0;
          s_d.time_out_flag = 1'b1;
          wdt_clear = 1'b1;
        end else if (timeout) begin
          s_d.time_out_flag = 1'b0;
          s_d.wdt_reset_req = 1'b1;
          wdt_clear = 1'b1;
        end
        // with global disable and a pending source the sleep is a no-op
      end
      SWC_SLEEP: begin
        if (irq_pending) begin
          s_d.st = SWC_WAKE;
          s_d.cpu_clk_en = 1'b1;
          wdt_clear = 1'b1;
        end else if (timeout) begin
          s_d.st = SWC_WAKE;
          s_d.cpu_clk_en = 1'b1;
          s_d.time_out_flag = 1'b0;
          wdt_clear = 1'b1;
        end
      end
      SWC_WAKE: begin
        // prefetched next instruction runs, then vector if enabled
        s_d.st = SWC_RUN;
        s_d.wake_pulse = 1'b1;
        s_d.vector_req = global_irq_enable;
        wdt_clear = 1'b1;
      end
      default: s_d.st = SWC_RUN;
    endcase

    if (wdt_clear) begin
      s_d.count = '0;
    end else if (lf_tick) begin
      s_d.count = s_q.count + 23'(1);
    end

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        SWC_ADDR_WDCON: begin
          s_d.watchdog_period_sel = bus.wdata[SWC_WDCON_PS_LSB +: 5];
          s_d.soft_watchdog_enable = bus.wdata[SWC_WDCON_EN_BIT];
        end
        SWC_ADDR_IRQ_EN: s_d.irq_en = bus.wdata;
        default: s_d.irq_en = s_d.irq_en;
      endcase
    end

    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        SWC_ADDR_STATUS: begin
          s_d.rdata[SWC_STATUS_TO_BIT] = s_q.time_out_flag;
          s_d.rdata[SWC_STATUS_PD_BIT] = s_q.power_down_flag;
        end
        SWC_ADDR_WDCON: s_d.rdata = {2'h0, s_q.watchdog_period_sel, s_q.soft_watchdog_enable};
        SWC_ADDR_IRQ_EN: s_d.rdata = s_q.irq_en;
        SWC_ADDR_IRQ_FLAG: s_d.rdata = irq_flags;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // any reset restarts everything; sleep has no say over rst
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q.st <= SWC_RUN;
      s_q.count <= '0;
      s_q.power_down_flag <= 1'b1;
      s_q.time_out_flag <= 1'b1;
      s_q.watchdog_period_sel <= SWC_PS_RESET;
      s_q.soft_watchdog_enable <= 1'b0;
      s_q.irq_en <= SWC_IRQ_EN_RESET;
      s_q.rdata <= 8'h00;
      s_q.cpu_clk_en <= 1'b1;
      s_q.wake_pulse <= 1'b0;
      s_q.vector_req <= 1'b0;
      s_q.wdt_reset_req <= 1'b0;
      s_q.hf_keep <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign cpu_clk_en = s_q.cpu_clk_en;
  assign wake_pulse = s_q.wake_pulse;
  assign vector_req = s_q.vector_req;
  assign wdt_reset_req = s_q.wdt_reset_req;
  assign hf_osc_keep = s_q.hf_keep;
  // low-frequency oscillator never stops, pins are not touched here
  assign lf_osc_run = 1'b1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sleep_entry;
    @(posedge clk_sys) disable iff (rst)
      (s_q.st == SWC_RUN && core_req.sleep && !irq_pending) |=>
        (s_q.st == SWC_SLEEP && !cpu_clk_en && !s_q.power_down_flag && s_q.time_out_flag && s_q.count == 0);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

  property p_noop;
    @(posedge clk_sys) disable iff (rst)
      (s_q.st == SWC_RUN && core_req.sleep && irq_pending && !global_irq_enable && !timeout) |=>
        (s_q.st == SWC_RUN && $stable(s_q.power_down_flag) && $stable(s_q.time_out_flag));
  endproperty
  a_noop: assert property (p_noop) else $error("sleep not a no-op");

  sequence s_wake_seq;
    ##1 (s_q.st == SWC_WAKE && cpu_clk_en) ##1 wake_pulse;
  endsequence
  property p_irq_wake;
    @(posedge clk_sys) disable iff (rst)
      (s_q.st == SWC_SLEEP && irq_pending) |-> s_wake_seq;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("no wake on interrupt");

  property p_vector;
    @(posedge clk_sys) disable iff (rst)
      wake_pulse |-> (vector_req == $past(global_irq_enable));
  endproperty
  a_vector: assert property (p_vector) else $error("vector request wrong");

  property p_awake_timeout;
    @(posedge clk_sys) disable iff (rst)
      (s_q.st == SWC_RUN && timeout && !core_req.sleep) |=> (wdt_reset_req && !s_q.time_out_flag);
  endproperty
  a_awake_timeout: assert property (p_awake_timeout) else $error("awake timeout no reset");

  property p_sleep_timeout;
    @(posedge clk_sys) disable iff (rst)
      (s_q.st == SWC_SLEEP && timeout && !irq_pending) |=> (!wdt_reset_req && s_q.st == SWC_WAKE);
  endproperty
  a_sleep_timeout: assert property (p_sleep_timeout) else $error("sleep timeout reset");

  property p_off_clear;
    @(posedge clk_sys) disable iff (rst)
      (watchdog_mode_cfg == SWC_MODE_OFF) |=> (s_q.count == 0);
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("disabled watchdog counts");

  property p_wake_clear;
    @(posedge clk_sys) disable iff (rst)
      wake_pulse |-> (s_q.count == 0);
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake did not clear");

endmodule

/* File: swc_core_model.sv */
module swc_core_model
  import swc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // block outputs seen by the core
  input wire logic cpu_clk_en,
  input wire logic wake_pulse,
  input wire logic vector_req,
  // instruction requests
  output swc_core_req_t core_req
);
  timeunit 1ns;
  timeprecision 1ns;
  int wakes = 0;
  int vectors = 0;
  initial core_req = '0;
  // ----------------------------------------------------------------
  // one-cycle instruction request, only while the core clock runs
  // ----------------------------------------------------------------
  task automatic pulse(input swc_core_req_t r);
    @(posedge clk_sys iff cpu_clk_en === 1'b1);
    core_req <= r;
    @(posedge clk_sys);
    core_req <= '0;
  endtask
  // ----------------------------------------------------------------
  // prefetched instruction runs on wake, vector follows when enabled
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst && wake_pulse === 1'b1) begin
      wakes <= wakes + 1;
      if (vector_req === 1'b1) vectors <= vectors + 1;
    end
  end
endmodule

/* File: sleep_and_watchdog_control_tb.sv */
module sleep_and_watchdog_control_tb
  import swc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LFD = 2;
  localparam swc_core_req_t Q_SLP = 4'h8;
  localparam swc_core_req_t Q_CLR = 4'h4;
  localparam swc_core_req_t Q_FAIL = 4'h2;
  localparam swc_core_req_t Q_DIV = 4'h1;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic w; logic [7:0] e;} swc_row_t;
  typedef struct packed {logic [1:0] m; logic [7:0] c; logic [7:0] t;} swc_cfg_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] watchdog_mode_cfg = SWC_MODE_OFF;
  logic [7:0] irq_flags = 8'h00;
  logic hf_osc_users = 1'b0;
  swc_bus_req_t bus = '0;
  swc_core_req_t core_req;
  logic [7:0] rdata;
  logic cpu_clk_en, wake_pulse, vector_req, wdt_reset_req, lf_osc_run, hf_osc_keep;
  int fail_count = 0;
  int num_checks = 0;
  int rst_seen = 0;
  int n, r0, w0, v0;
  swc_row_t rows [7] = '{'{SWC_ADDR_WDCON, 8'h25, 1, 8'h25}, '{SWC_ADDR_WDCON, 8'hff, 1, 8'h3f},
    '{SWC_ADDR_STATUS, 8'h00, 1, 8'h18}, '{SWC_ADDR_IRQ_EN, 8'h81, 1, 8'h81},
    '{SWC_ADDR_IRQ_FLAG, 8'hff, 1, 8'h00}, '{4'h9, 8'h55, 1, 8'h00}, '{SWC_ADDR_IRQ_EN, 8'h00, 1, 8'h00}};
  swc_cfg_t cfgs [7] = '{'{SWC_MODE_ON, 8'h00, 8'h20}, '{SWC_MODE_ON, 8'h02, 8'h40},
    '{SWC_MODE_ON, 8'h26, 8'h20}, '{SWC_MODE_OFF, 8'h01, 8'h00}, '{SWC_MODE_SOFT, 8'h00, 8'h00},
    '{SWC_MODE_SOFT, 8'h01, 8'h20}, '{SWC_MODE_AWAKE, 8'h00, 8'h20}};

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wdt_reset_req === 1'b1) rst_seen <= rst_seen + 1;

  swc_sleep_wdt #(.LF_DIV(LFD)) swc_sleep_wdt_i (.clk_sys(clk_sys), .rst(rst),
    .watchdog_mode_cfg(watchdog_mode_cfg), .core_req(core_req), .irq_flags(irq_flags), .bus(bus),
    .rdata(rdata), .cpu_clk_en(cpu_clk_en), .wake_pulse(wake_pulse), .vector_req(vector_req),
    .wdt_reset_req(wdt_reset_req), .lf_osc_run(lf_osc_run), .hf_osc_keep(hf_osc_keep),
    .hf_osc_users(hf_osc_users));
  swc_core_model swc_core_model_i (.clk_sys(clk_sys), .rst(rst), .cpu_clk_en(cpu_clk_en),
    .wake_pulse(wake_pulse), .vector_req(vector_req), .core_req(core_req));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 check(rdata, exp);
  endtask
  // count edges until reset request (sel 0) or core clock back (sel 1)
  task automatic wait_sig(input logic sel, input int lim, output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (k < lim && ((sel ? cpu_clk_en : wdt_reset_req) !== 1'b1));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(SWC_ADDR_STATUS, 8'h18);
    rd(SWC_ADDR_WDCON, 8'h16);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    hf_osc_users <= 1'b1;
    cyc(3);
    check(hf_osc_keep, 1'b1);
    check(lf_osc_run, 1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(SWC_ADDR_WDCON, 8'h16);
    // awake time-out per mode and period code
    foreach (cfgs[i]) begin
      watchdog_mode_cfg <= cfgs[i].m;
      wr(SWC_ADDR_WDCON, cfgs[i].c);
      swc_core_model_i.pulse(Q_CLR);
      wait_sig(1'b0, 300, n);
      check((cfgs[i].t == 0) ? (n == 300) : (n >= cfgs[i].t * LFD - 4 && n <= cfgs[i].t * LFD + 4), 1);
    end
    rd(SWC_ADDR_STATUS, 8'h08);
    // divider change keeps the count, oscillator failure clears it
    watchdog_mode_cfg <= SWC_MODE_ON;
    wr(SWC_ADDR_WDCON, 8'h00);
    swc_core_model_i.pulse(Q_CLR);
    cyc(20);
    swc_core_model_i.pulse(Q_DIV);
    wait_sig(1'b0, 300, n);
    check(n >= 32 * LFD - 26 && n <= 32 * LFD - 18, 1);
    swc_core_model_i.pulse(Q_CLR);
    cyc(20);
    swc_core_model_i.pulse(Q_FAIL);
    wait_sig(1'b0, 300, n);
    check(n >= 32 * LFD - 4 && n <= 32 * LFD + 4, 1);
    // sleep with an enabled pending flag and global enable clear
    wr(SWC_ADDR_IRQ_EN, 8'h01);
    irq_flags <= 8'h01;
    swc_core_model_i.pulse(Q_CLR);
    cyc(20);
    swc_core_model_i.pulse(Q_SLP);
    cyc(1);
    check(cpu_clk_en, 1'b1);
    rd(SWC_ADDR_STATUS, 8'h08);
    wait_sig(1'b0, 300, n);
    check(n >= 32 * LFD - 30 && n <= 32 * LFD - 18, 1);
    irq_flags <= 8'h00;
    // interrupt wake with global enable clear, then set
    watchdog_mode_cfg <= SWC_MODE_OFF;
    for (int g = 0; g < 2; g++) begin
      wr(SWC_ADDR_IRQ_EN, {g[0], 7'h01});
      swc_core_model_i.pulse(Q_SLP);
      cyc(1);
      check(cpu_clk_en, 1'b0);
      rd(SWC_ADDR_STATUS, 8'h10);
      irq_flags <= 8'h82;
      cyc(5);
      check(cpu_clk_en, 1'b0);
      w0 = swc_core_model_i.wakes;
      v0 = swc_core_model_i.vectors;
      irq_flags <= 8'h83;
      wait_sig(1'b1, 10, n);
      check(n <= 2, 1);
      cyc(2);
      check(swc_core_model_i.wakes - w0, 1);
      check(swc_core_model_i.vectors - v0, g);
      irq_flags <= 8'h00;
    end
    // time-out in sleep wakes without reset
    watchdog_mode_cfg <= SWC_MODE_ON;
    wr(SWC_ADDR_IRQ_EN, 8'h00);
    r0 = rst_seen;
    swc_core_model_i.pulse(Q_SLP);
    wait_sig(1'b1, 300, n);
    check(n >= 32 * LFD - 4 && n <= 32 * LFD + 4, 1);
    check(rst_seen - r0, 0);
    rd(SWC_ADDR_STATUS, 8'h00);
    wait_sig(1'b0, 300, n);
    check(n >= 32 * LFD - 12 && n <= 32 * LFD + 2, 1);
    // awake-only mode sleeps through
    watchdog_mode_cfg <= SWC_MODE_AWAKE;
    wr(SWC_ADDR_IRQ_EN, 8'h01);
    r0 = rst_seen;
    swc_core_model_i.pulse(Q_SLP);
    cyc(200);
    check(cpu_clk_en, 1'b0);
    check(rst_seen - r0, 0);
    irq_flags <= 8'h01;
    wait_sig(1'b1, 10, n);
    check(n <= 2, 1);
    irq_flags <= 8'h00;
    complete_run();
  end
endmodule
